// [design/dcr_params.svh]
/*
 Constants for the converter register control block: register addresses,
 selector codes, field positions and reset values.
 Assumes it is included by the design module and the test bench.
*/
`ifndef DCR_PARAMS_SVH
`define DCR_PARAMS_SVH

`define DCR_ADDR_LOW 8'hB5
`define DCR_ADDR_HIGH 8'hB6
`define DCR_ADDR_SEL 8'hB7
`define DCR_SEL_DATA_MAX 8'h03
`define DCR_SEL_CTRL01 8'h04
`define DCR_SEL_CTRL23 8'h05
`define DCR_SEL_LOAD 8'h06
`define DCR_CTRL01_RST 8'h63
`define DCR_CTRL23_RST 8'h03
`define DCR_BIT_COR 7
`define DCR_BIT_EOD 6
`define DCR_BIT_IOFF 5
`define DCR_BIT_SINK 4
`define DCR_BIT_REF 2
`define DCR_MODE_NORMAL 2'h0
`define DCR_LOAD_DIRECT 2'h0
`define DCR_LOAD_MILLISECOND_TICK 2'h1
`define DCR_LOAD_HALF_MILLISECOND_TICK 2'h2
`define DCR_LOAD_SYNC 2'h3
`define DCR_OC_TICKS 2'h3
`define DCR_MASK01 8'hF7
`define DCR_MASK23 8'h07

`endif

// [design/dcr_pkg.sv]
/*
 Types for the converter register control block.
 Assumes the params header sits in the include path.
*/
package dcr_pkg;
    typedef struct packed {
        logic cor;
        logic eod;
        logic ioff;
        logic sink;
        logic ref_sel;
        logic [1:0] mode;
    } dcr_ctrl_t;

    typedef struct packed {
        logic [3:0][15:0] held;
        logic [3:0][15:0] out;
        logic [3:0] pend;
        logic [3:0] hiz;
        logic [1:0][1:0] oc_cnt;
        dcr_ctrl_t [3:0] ctrl;
        logic [7:0] load;
        logic [7:0] sel;
        logic [7:0] rdata;
        logic [1:0][1:0] sync;
    } dcr_state_t;
endpackage

// [design/dcr_top.sv]
/*
 Indirect register control for up to four 16-bit converter channels on the
 core's special function register bus: two byte windows, a selector,
 per-channel control, output load timing and over-current protection.
 Assumes SFR accesses are single-cycle strobes in the core clock domain,
 tick strobes are one-cycle pulses from the core's system timers, and the
 over-range signals come from the analog side and are synchronised here.
*/
`timescale 1ns/1ps
`include "dcr_params.svh"

// How it works
// - Windows reach the register picked by selector; 00h-03h are channel data
// - 04h: control 0/1, 05h: control 2/3, 06h low: load control, else none
// - With detection on, third consecutive overcurrent tick forces high impedance
// - Over-range bit reads latched trip, or raw signal when detection off
// - Writing 0 releases high impedance unless over-range persists; 1 does nothing
// - Control registers of channels 0 and 1 reset to 63h
// - Bit 5 turns current output on at 0, only in normal mode
// - Bit 4 picks sourcing at 0 or sinking at 1
// - Bit 2 of channels 0/1 picks supply or external reference
// - Bit 2 of channels 2/3 picks supply or internal reference
// - Mode field: normal, 1k, 100k, high impedance; power-down kills current
// - Channels 2/3 control hold reference and mode only, reset 03h
// - High window is data MSB, low window LSB, data resets zero
// - Channels 2 and 3 exist only when the four-channel parameter is set
// - Load field: low-byte write, ms tick, half-ms tick, or immediate sync
module dcr_top
    import dcr_pkg::*;
#(
    parameter bit FOUR_CH = 1'b1
)(
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic SFR_WR_I,
    input wire logic SFR_RD_I,
    input wire logic [7:0] SFR_ADDR_I,
    input wire logic [7:0] SFR_WDATA_I,
    input wire logic MILLISECOND_TICK_I,
    input wire logic HALF_MILLISECOND_TICK_I,
    input wire logic [1:0] OVERRANGE_RAW_I,
    output logic [7:0] SFR_RDATA_O,
    output logic [63:0] DAC_CODE_O,
    output logic [7:0] OUTPUT_MODE_O,
    output logic [3:0] REFERENCE_CHOICE_O,
    output logic [1:0] CURRENT_ON_O,
    output logic [1:0] CURRENT_DIRECTION_O,
    output logic [3:0] OUTPUT_HIZ_O
);

    dcr_state_t s;
    dcr_state_t next_s;
    logic [3:0] ch_en;
    logic [1:0] ovr;
    logic wr_lo;
    logic wr_hi;
    logic wr_sel;
    logic [7:0] rd_lo;
    logic [7:0] rd_hi;

    // Bit 3 has no storage, so the byte is packed field by field
    localparam logic [7:0] CTRL01_RST = `DCR_CTRL01_RST;
    localparam logic [7:0] CTRL23_RST = `DCR_CTRL23_RST;
    localparam dcr_ctrl_t CTRL01_INIT = {CTRL01_RST[7:4], CTRL01_RST[2:0]};
    localparam dcr_ctrl_t CTRL23_INIT = {CTRL23_RST[7:4], CTRL23_RST[2:0]};

    assign ch_en = FOUR_CH ? 4'hF : 4'h3;
    assign wr_lo = SFR_WR_I && (SFR_ADDR_I == `DCR_ADDR_LOW);
    assign wr_hi = SFR_WR_I && (SFR_ADDR_I == `DCR_ADDR_HIGH);
    assign wr_sel = SFR_WR_I && (SFR_ADDR_I == `DCR_ADDR_SEL);
    // Only the second stage of the synchroniser is read
    assign ovr = s.sync[1];

    function automatic logic [7:0] ctrl_rd(input dcr_ctrl_t c,
                                           input logic full,
                                           input logic raw);
        logic [7:0] v;
        v = 8'h00;
        v[`DCR_BIT_REF] = c.ref_sel;
        v[1:0] = c.mode;
        if (full)
        begin
            v[`DCR_BIT_COR] = c.eod ? c.cor : raw;
            v[`DCR_BIT_EOD] = c.eod;
            v[`DCR_BIT_IOFF] = c.ioff;
            v[`DCR_BIT_SINK] = c.sink; // bit 3 stays zero
        end
        return v;
    endfunction

    always_comb
    begin
        rd_lo = 8'h00;
        rd_hi = 8'h00;
        if (s.sel <= `DCR_SEL_DATA_MAX)
        begin
            if (ch_en[s.sel[1:0]])
            begin
                rd_lo = s.held[s.sel[1:0]][7:0];
                rd_hi = s.held[s.sel[1:0]][15:8];
            end
        end
        else if (s.sel == `DCR_SEL_CTRL01)
        begin
            rd_lo = ctrl_rd(s.ctrl[0], 1'b1, ovr[0]);
            rd_hi = ctrl_rd(s.ctrl[1], 1'b1, ovr[1]);
        end
        else if (s.sel == `DCR_SEL_CTRL23 && FOUR_CH)
        begin
            rd_lo = ctrl_rd(s.ctrl[2], 1'b0, 1'b0);
            rd_hi = ctrl_rd(s.ctrl[3], 1'b0, 1'b0);
        end
        else if (s.sel == `DCR_SEL_LOAD)
        begin
            rd_lo = s.load;
        end
    end

    always_comb
    begin
        next_s = s;
        next_s.sync[0] = OVERRANGE_RAW_I;
        next_s.sync[1] = s.sync[0];
        if (SFR_RD_I)
        begin
            unique case (SFR_ADDR_I)
                `DCR_ADDR_LOW: next_s.rdata = rd_lo;
                `DCR_ADDR_HIGH: next_s.rdata = rd_hi;
                `DCR_ADDR_SEL: next_s.rdata = s.sel;
                default: next_s.rdata = 8'h00;
            endcase
        end
        if (wr_sel)
        begin
            next_s.sel = SFR_WDATA_I;
        end

        // Data windows and load timing, one pass per channel
        for (int i = 0; i < 4; i++)
        begin
            if (ch_en[i])
            begin
                if (s.sel == 8'(i) && wr_lo)
                begin
                    next_s.held[i][7:0] = SFR_WDATA_I;
                    if (s.load[2*i +: 2] == `DCR_LOAD_DIRECT)
                    begin
                        next_s.out[i] = {s.held[i][15:8], SFR_WDATA_I};
                    end
                    else
                    begin
                        next_s.pend[i] = 1'b1;
                    end
                end
                if (s.sel == 8'(i) && wr_hi)
                begin
                    next_s.held[i][15:8] = SFR_WDATA_I;
                    next_s.pend[i] = 1'b1;
                end
                if (s.pend[i] &&
                    ((s.load[2*i +: 2] == `DCR_LOAD_MILLISECOND_TICK &&
                      MILLISECOND_TICK_I) ||
                     (s.load[2*i +: 2] == `DCR_LOAD_HALF_MILLISECOND_TICK &&
                      HALF_MILLISECOND_TICK_I)))
                begin
                    next_s.out[i] = s.held[i];
                    next_s.pend[i] = 1'b0;
                end
            end
        end

        if (s.sel == `DCR_SEL_LOAD && wr_lo)
        begin
            next_s.load = FOUR_CH ? SFR_WDATA_I
                                  : {4'h0, SFR_WDATA_I[3:0]};
            // Sync load copies the held value at the write itself
            for (int i = 0; i < 4; i++)
            begin
                if (ch_en[i] &&
                    SFR_WDATA_I[2*i +: 2] == `DCR_LOAD_SYNC)
                begin
                    next_s.out[i] = s.held[i];
                    next_s.pend[i] = 1'b0;
                end
            end
        end

        // Channels 0 and 1: full control plus over-current guard
        for (int i = 0; i < 2; i++)
        begin
            if (s.sel == `DCR_SEL_CTRL01 && ((i == 0) ? wr_lo : wr_hi))
            begin
                next_s.ctrl[i].eod = SFR_WDATA_I[`DCR_BIT_EOD];
                next_s.ctrl[i].ioff = SFR_WDATA_I[`DCR_BIT_IOFF];
                next_s.ctrl[i].sink = SFR_WDATA_I[`DCR_BIT_SINK];
                next_s.ctrl[i].ref_sel = SFR_WDATA_I[`DCR_BIT_REF];
                next_s.ctrl[i].mode = SFR_WDATA_I[1:0];
                if (!SFR_WDATA_I[`DCR_BIT_COR] && !ovr[i])
                begin
                    next_s.ctrl[i].cor = 1'b0;
                    next_s.hiz[i] = 1'b0;
                end
            end
            // Counter only advances on ms ticks, so it counts ticks
            if (!s.ctrl[i].eod || !ovr[i])
            begin
                next_s.oc_cnt[i] = 2'h0;
            end
            else if (MILLISECOND_TICK_I && !s.hiz[i])
            begin
                if (s.oc_cnt[i] == `DCR_OC_TICKS - 2'h1)
                begin
                    // Trip beats a same-cycle clear
                    next_s.oc_cnt[i] = 2'h0;
                    next_s.hiz[i] = 1'b1;
                    next_s.ctrl[i].cor = 1'b1;
                end
                else
                begin
                    next_s.oc_cnt[i] = s.oc_cnt[i] + 2'h1;
                end
            end
        end

        // Channels 2 and 3: reference and mode only
        for (int i = 2; i < 4; i++)
        begin
            if (FOUR_CH && s.sel == `DCR_SEL_CTRL23 &&
                ((i == 2) ? wr_lo : wr_hi))
            begin
                next_s.ctrl[i].ref_sel = SFR_WDATA_I[`DCR_BIT_REF];
                next_s.ctrl[i].mode = SFR_WDATA_I[1:0];
            end
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            s <= '0;
            s.ctrl[0] <= CTRL01_INIT;
            s.ctrl[1] <= CTRL01_INIT;
            s.ctrl[2] <= CTRL23_INIT;
            s.ctrl[3] <= CTRL23_INIT;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs: current path is live only in normal mode and not tripped
    always_comb
    begin
        SFR_RDATA_O = s.rdata;
        DAC_CODE_O = {s.out[3], s.out[2], s.out[1], s.out[0]};
        OUTPUT_MODE_O = {s.ctrl[3].mode, s.ctrl[2].mode,
                         s.ctrl[1].mode, s.ctrl[0].mode};
        REFERENCE_CHOICE_O = {s.ctrl[3].ref_sel, s.ctrl[2].ref_sel,
                              s.ctrl[1].ref_sel, s.ctrl[0].ref_sel};
        OUTPUT_HIZ_O = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            OUTPUT_HIZ_O[i] = s.hiz[i] ||
                (s.ctrl[i].mode != `DCR_MODE_NORMAL);
        end
        for (int i = 0; i < 2; i++)
        begin
            CURRENT_ON_O[i] = !s.ctrl[i].ioff && !s.hiz[i] &&
                (s.ctrl[i].mode == `DCR_MODE_NORMAL);
            CURRENT_DIRECTION_O[i] = s.ctrl[i].sink;
        end
    end

endmodule // dcr_top

// [tb/dcr_chk.sv]
/*
 Port assertions for the converter register block.
 Assumes a bind to dcr_top and one clock domain.
*/
`timescale 1ns/1ps
module dcr_chk (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic SFR_WR_I,
    input wire logic SFR_RD_I,
    input wire logic [7:0] SFR_ADDR_I,
    input wire logic MILLISECOND_TICK_I,
    input wire logic HALF_MILLISECOND_TICK_I,
    input wire logic [7:0] SFR_RDATA_O,
    input wire logic [63:0] DAC_CODE_O,
    input wire logic [7:0] OUTPUT_MODE_O,
    input wire logic [3:0] REFERENCE_CHOICE_O,
    input wire logic [1:0] CURRENT_ON_O,
    input wire logic [1:0] CURRENT_DIRECTION_O,
    input wire logic [3:0] OUTPUT_HIZ_O
);
    logic [1:0] wh;
    logic [1:0] th;
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    // Outputs may trail their cause by one or two edges
    always_ff @(posedge REF_CLK_I)
    begin
        wh <= {wh[0], SFR_WR_I};
        th <= {th[0], MILLISECOND_TICK_I | HALF_MILLISECOND_TICK_I};
    end
    a_rst_state: assert property ($rose(RST_N_I) |->
        DAC_CODE_O == 64'h0 && OUTPUT_MODE_O == 8'hFF && OUTPUT_HIZ_O == 4'hF)
        else $error("outputs wrong after reset");
    a_code_cause: assert property ($changed(DAC_CODE_O) |-> |{wh, th})
        else $error("code changed without write or tick");
    a_mode_cause: assert property ($changed(OUTPUT_MODE_O) |-> |wh)
        else $error("mode changed without a write");
    a_sel_cause: assert property (
        $changed({REFERENCE_CHOICE_O, CURRENT_DIRECTION_O}) |-> |wh)
        else $error("reference or direction changed without a write");
    a_cur_gate: assert property (
        (CURRENT_ON_O & (OUTPUT_HIZ_O[1:0] |
        {|OUTPUT_MODE_O[3:2], |OUTPUT_MODE_O[1:0]})) == 2'h0)
        else $error("current on outside normal mode");
    a_hiz_mode: assert property (
        OUTPUT_HIZ_O[3:2] == {|OUTPUT_MODE_O[7:6], |OUTPUT_MODE_O[5:4]}
        && (OUTPUT_MODE_O[1:0] == 2'h0 || OUTPUT_HIZ_O[0]))
        else $error("high impedance does not follow mode");
    a_unmapped_rd: assert property (
        SFR_RD_I && (SFR_ADDR_I < 8'hB5 || SFR_ADDR_I > 8'hB7)
        |=> SFR_RDATA_O == 8'h00) else $error("unmapped read not zero");
    a_trip_tick: assert property (
        $rose(OUTPUT_HIZ_O[0]) && OUTPUT_MODE_O[1:0] == 2'h0
        && $stable(OUTPUT_MODE_O[1:0]) |-> |th)
        else $error("trip without a tick");
endmodule // dcr_chk

// [tb/dcr_core.sv]
/*
 Core timer model: millisecond and half-millisecond tick strobes.
 Assumes the block's clock and reset.
*/
`timescale 1ns/1ps
module dcr_core #(
    parameter int MS_CYC = 40
)(
    input wire logic clk_i,
    input wire logic rst_n_i,
    output logic ms_o,
    output logic hms_o
);
    int cnt;
    // Short period stands in for a real millisecond to keep runs short
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt <= 0;
            ms_o <= 1'b0;
            hms_o <= 1'b0;
        end
        else
        begin
            cnt <= (cnt == MS_CYC - 1) ? 0 : cnt + 1;
            ms_o <= cnt == MS_CYC - 1;
            hms_o <= cnt == MS_CYC - 1 || cnt == MS_CYC / 2 - 1;
        end
    end
endmodule // dcr_core

// [tb/dcr_test.sv]
/*
 Self-checking bench for the converter register block.
 Assumes dcr_top, dcr_core and dcr_chk are compiled first.
*/
`timescale 1ns/1ps
`include "dcr_params.svh"
module dac_indirect_register_control_test;
    localparam logic [7:0] a_lo = `DCR_ADDR_LOW;
    localparam logic [7:0] a_hi = `DCR_ADDR_HIGH;
    localparam logic [7:0] a_sel = `DCR_ADDR_SEL;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [1:0] raw = 2'h0;
    logic ms, hms;
    logic [7:0] rdata, mode, d, w;
    logic [63:0] code;
    logic [3:0] refc, hiz;
    logic [1:0] con, dir;
    logic [15:0] v [4];
    logic [15:0] x;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    int seed = 32'h7f8d;
    int ch;
    dcr_top #(.FOUR_CH(1'b1)) dut (.REF_CLK_I(clk), .RST_N_I(rst_n),
        .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_ADDR_I(addr),
        .SFR_WDATA_I(wdata), .MILLISECOND_TICK_I(ms),
        .HALF_MILLISECOND_TICK_I(hms), .OVERRANGE_RAW_I(raw),
        .SFR_RDATA_O(rdata), .DAC_CODE_O(code), .OUTPUT_MODE_O(mode),
        .REFERENCE_CHOICE_O(refc), .CURRENT_ON_O(con),
        .CURRENT_DIRECTION_O(dir), .OUTPUT_HIZ_O(hiz));
    dcr_core #(.MS_CYC(40)) core (.clk_i(clk), .rst_n_i(rst_n),
        .ms_o(ms), .hms_o(hms));
    initial
    begin
        forever #10 clk = ~clk;
    end
    task automatic finish_test();
        if (n_fail == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            finish_test();
        end
    end
    task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("MISMATCH %s exp %h got %h", nm, e, g);
            n_fail++;
        end
    endtask
    task automatic wr_reg(logic [7:0] a, logic [7:0] dt);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= dt;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(logic [7:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Waits n ticks, then lets the outputs land
    task automatic ticks(int n, bit h);
        repeat (n)
        begin
            @(posedge clk);
            while (!(h ? hms : ms)) @(posedge clk);
        end
        repeat (3) @(posedge clk);
        #1;
    endtask
    function automatic logic [7:0] rst_exp(logic [2:0] s);
        return s == 3'h4 ? 8'h63 : s == 3'h5 ? 8'h03 : 8'h00;
    endfunction
    function automatic logic [7:0] ctl_exp(int c, logic [7:0] b);
        return b & (c < 2 ? 8'h77 : 8'h07);
    endfunction
    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (int s = 0; s < 16; s++)
        begin
            wr_reg(a_sel, {5'h00, s[3:1]});
            rd_reg(a_lo + {7'h00, s[0]});
            chk("reset read", rst_exp(s[3:1]), d);
        end
        rd_reg(8'hB4);
        chk("unmapped", 8'h00, d);
        for (int c = 0; c < 4; c++)
        begin
            v[c] = 16'($random(seed));
            wr_reg(a_sel, 8'(c));
            wr_reg(a_hi, v[c][15:8]);
            wr_reg(a_lo, v[c][7:0]);
        end
        rd_reg(a_hi);
        chk("high readback", v[3][15:8], d);
        chk("codes", {v[3], v[2], v[1], v[0]}, code);
        for (int i = 0; i < 12; i++)
        begin
            ch = i % 4;
            w = 8'($random(seed)) & (i < 4 ? 8'hDC : 8'hFF);
            wr_reg(a_sel, 8'(4 + ch / 2));
            wr_reg(a_lo + 8'(ch % 2), w);
            rd_reg(a_lo + 8'(ch % 2));
            chk("control", ctl_exp(ch, w), d);
            chk("mode", w[1:0], mode[2 * ch +: 2]);
            chk("reference", w[2], refc[ch]);
            if (ch < 2)
            begin
                chk("direction", w[4], dir[ch]);
                chk("current", !w[5] && w[1:0] == 2'h0, con[ch]);
            end
        end
        wr_reg(a_sel, 8'h04);
        wr_reg(a_lo, 8'h40);
        wr_reg(a_hi, 8'h03);
        ticks(1, 1'b0);
        raw <= 2'h3;
        ticks(2, 1'b0);
        chk("hiz early", 1'b0, hiz[0]);
        ticks(1, 1'b0);
        chk("hiz trip", 1'b1, hiz[0]);
        chk("current trip", 1'b0, con[0]);
        chk("codes kept", {v[3], v[2], v[1], v[0]}, code);
        rd_reg(a_lo);
        chk("flag latched", 8'hC0, d);
        rd_reg(a_hi);
        chk("flag raw", 8'h83, d);
        wr_reg(a_lo, 8'h40);
        ticks(0, 1'b0);
        chk("clear refused", 1'b1, hiz[0]);
        raw <= 2'h0;
        ticks(0, 1'b0);
        wr_reg(a_lo, 8'h40);
        rd_reg(a_lo);
        chk("cleared", 8'h40, d);
        chk("released", 1'b0, hiz[0]);
        for (int m = 1; m < 4; m++)
        begin
            x = 16'($random(seed));
            wr_reg(a_sel, 8'h06);
            wr_reg(a_lo, m == 3 ? 8'h01 : 8'(m));
            wr_reg(a_sel, 8'h00);
            ticks(1, m == 2);
            wr_reg(a_hi, x[15:8]);
            wr_reg(a_lo, x[7:0]);
            ticks(0, 1'b0);
            chk("held code", v[0], code[15:0]);
            if (m == 3)
            begin
                wr_reg(a_sel, 8'h06);
                wr_reg(a_lo, 8'h03);
            end
            ticks(m < 3, m == 2);
            chk("loaded code", x, code[15:0]);
            v[0] = x;
        end
        finish_test();
    end
endmodule // dac_indirect_register_control_test
bind dcr_top dcr_chk chk (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I),
    .SFR_WR_I(SFR_WR_I), .SFR_RD_I(SFR_RD_I), .SFR_ADDR_I(SFR_ADDR_I),
    .MILLISECOND_TICK_I(MILLISECOND_TICK_I),
    .HALF_MILLISECOND_TICK_I(HALF_MILLISECOND_TICK_I),
    .SFR_RDATA_O(SFR_RDATA_O), .DAC_CODE_O(DAC_CODE_O),
    .OUTPUT_MODE_O(OUTPUT_MODE_O), .REFERENCE_CHOICE_O(REFERENCE_CHOICE_O),
    .CURRENT_ON_O(CURRENT_ON_O), .CURRENT_DIRECTION_O(CURRENT_DIRECTION_O),
    .OUTPUT_HIZ_O(OUTPUT_HIZ_O));
